//--- ilo_addr_gen.sv
// Effective data address generator
`timescale 1ns/1ns
`include "ilo_consts.svh"
module ilo_addr_gen
#(
   parameter int AW = 12
)
(
   // Mode and operand
   input wire logic ext_en,
   input wire logic acc_sel,
   input wire logic [7:0] fld,
   // Pointers
   input wire logic [AW-1:0] frame_ptr,
   input wire logic [3:0] bank_sel,
   // Result
   output logic [AW-1:0] addr,
   output logic indexed
);
   // ********************
   // Address choice
   // ********************
   always_comb
   begin
      // Offset only with extended mode, access bank, field in range
      indexed = ext_en && !acc_sel && (fld <= `ILO_OFS_MAX);
      if (indexed)
      begin
         addr = AW'(frame_ptr + AW'(fld));
      end
      else if (acc_sel)
      begin
         addr = AW'({bank_sel, fld}); // Banked access
      end
      else if (fld[7])
      begin
         addr = AW'({4'hf, fld}); // Upper access bank: special registers
      end
      else
      begin
         addr = AW'({4'h0, fld}); // Lower access bank
      end
   end
endmodule

//--- ilo_consts.svh
// Constants for the indexed literal offset execution block
`ifndef ILO_CONSTS_SVH
`define ILO_CONSTS_SVH
// Highest access-bank address that is taken as an offset
`define ILO_OFS_MAX 8'h5f
// Opcode patterns
`define ILO_OP_ADD_HI 6'h09
`define ILO_OP_BITSET_HI 4'h8
`define ILO_OP_FILL_HI 8'h68
// Value written by the fill instruction
`define ILO_FILL_VAL 8'hff
// Status flag bit positions
`define ILO_FLG_C 0
`define ILO_FLG_DIGIT 1
`define ILO_FLG_Z 2
`define ILO_FLG_OVFL 3
`define ILO_FLG_N 4
// Reset values
`define ILO_ACC_RST 8'h00
`define ILO_STAT_RST 5'h00
`define ILO_FP_RST 12'h000
`define ILO_BSR_RST 4'h0
`endif

//--- ilo_dec_if.sv
// Interface carrying decoded fields between decoder and top
`timescale 1ns/1ns
interface ilo_dec_if;
   import ilo_pkg::*;
   ilo_op_t op; // Decoded operation
   logic dest_mem; // Sum goes back to memory when high
   logic [2:0] bit_sel; // Bit number for bit set
   logic [7:0] fld; // Raw 8-bit address or offset field
   logic acc_sel; // Access-select bit of the opcode
   modport dec (output op, dest_mem, bit_sel, fld, acc_sel);
   modport use_side (input op, dest_mem, bit_sel, fld, acc_sel);
endinterface

//--- ilo_decoder.sv
// Combinational opcode decoder for the three indexed instructions
`timescale 1ns/1ns
`include "ilo_consts.svh"
module ilo_decoder
(
   // Instruction word
   input wire logic [15:0] instr,
   // Decoded fields
   ilo_dec_if.dec dec
);
   import ilo_pkg::*;

   // ********************
   // Decode
   // ********************
   // The fill pattern is tested before add; the two never overlap anyway
   always_comb
   begin
      dec.op = ILO_OP_NONE;
      dec.dest_mem = instr[9];
      dec.bit_sel = instr[11:9];
      dec.fld = instr[7:0];
      dec.acc_sel = instr[8];
      if (instr[15:8] == `ILO_OP_FILL_HI)
      begin
         dec.op = ILO_OP_FILL;
      end
      else if (instr[15:10] == `ILO_OP_ADD_HI)
      begin
         dec.op = ILO_OP_ADD;
      end
      else if (instr[15:12] == `ILO_OP_BITSET_HI)
      begin
         dec.op = ILO_OP_BSET;
      end
   end
endmodule

//--- ilo_exec.sv
// Indexed literal offset execution unit, top module
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`include "ilo_consts.svh"
module ilo_exec
#(
   parameter int AW = 12
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Configuration
   input wire logic extended_set_cfg_bit,
   // Instruction issue
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   // Pointers from the core
   input wire logic [AW-1:0] frame_pointer_reg,
   input wire logic [3:0] bank_sel,
   // Data memory read port, combinational
   output logic [AW-1:0] mem_addr,
   input wire logic [7:0] mem_rdata,
   // Data memory write port
   output logic mem_we,
   output logic [AW-1:0] mem_waddr,
   output logic [7:0] mem_wdata,
   // Core state
   output logic [7:0] acc,
   output logic [4:0] status,
   output ilo_pkg::ilo_phase_t phase,
   output logic busy,
   output logic done,
   output logic indexed_used
);
   import ilo_pkg::*;

   // ********************
   // Declarations
   // ********************
   ilo_dec_if dbus(); // Decoded fields
   logic [15:0] ir_r; // Latched instruction word
   logic [15:0] ir_nxt;
   logic busy_r; // Cycle in progress
   ilo_phase_t phase_r; // Current phase
   ilo_phase_t phase_nxt;
   logic [7:0] acc_r; // Accumulator
   logic [4:0] stat_r; // Status flags
   logic [AW-1:0] ea_r; // Effective address held from decode
   logic [AW-1:0] ea; // Effective address, combinational
   logic idx; // Offset addressing in force
   logic idx_r;
   logic [7:0] opnd_r; // Operand byte read in phase two
   logic [7:0] res_r; // Result from phase three
   logic [4:0] flg_r; // Flags computed in phase three
   logic we_r;
   logic [AW-1:0] wa_r;
   logic [7:0] wd_r;
   logic done_r;
   logic [8:0] sum; // Add with carry out
   logic [4:0] lo_sum; // Low nibble sum for digit carry
   logic ext_r; // Configuration bit registered

   // ********************
   // Submodules
   // ********************
   ilo_decoder u_dec
   (
      .instr(ir_r),
      .dec(dbus.dec)
   );

   ilo_addr_gen #(.AW(AW)) u_ag
   (
      .ext_en(ext_r),
      .acc_sel(dbus.acc_sel),
      .fld(dbus.fld),
      .frame_ptr(frame_pointer_reg),
      .bank_sel(bank_sel),
      .addr(ea),
      .indexed(idx)
   );

   // ********************
   // Configuration
   // ********************
   // Configuration bit is a fuse-like level; it is only sampled between cycles
   // so a change cannot tear one instruction
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         ext_r <= 1'b0;
      end
      else if (!busy_r || phase_r == ILO_PH_WRITE)
      begin
         // Taken at every issue edge, back-to-back ones included
         ext_r <= extended_set_cfg_bit;
      end
   end

   // ********************
   // Phase sequencer
   // ********************
   // One instruction per four clocks, no stalls
   always_comb
   begin
      case (phase_r)
         ILO_PH_DECODE: phase_nxt = ILO_PH_READ;
         ILO_PH_READ: phase_nxt = ILO_PH_PROC;
         ILO_PH_PROC: phase_nxt = ILO_PH_WRITE;
         ILO_PH_WRITE: phase_nxt = ILO_PH_DECODE;
         default: phase_nxt = ILO_PH_DECODE;
      endcase
   end

   // Instruction latch: a new word is taken only when idle or at cycle end
   assign ir_nxt = instr;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         busy_r <= 1'b0;
         phase_r <= ILO_PH_DECODE;
         ir_r <= 16'h0000;
      end
      else if (!busy_r || phase_r == ILO_PH_WRITE)
      begin
         // Start of a new instruction cycle
         busy_r <= instr_valid;
         phase_r <= ILO_PH_DECODE;
         if (instr_valid)
         begin
            ir_r <= ir_nxt;
         end
      end
      else
      begin
         phase_r <= phase_nxt;
      end
   end

   // ********************
   // Decode phase: address latch
   // ********************
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         ea_r <= '0;
         idx_r <= 1'b0;
      end
      else if (busy_r && phase_r == ILO_PH_DECODE)
      begin
         ea_r <= ea;
         idx_r <= idx;
      end
   end

   // ********************
   // Read phase
   // ********************
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         opnd_r <= 8'h00;
      end
      else if (busy_r && phase_r == ILO_PH_READ)
      begin
         opnd_r <= mem_rdata;
      end
   end

   // ********************
   // Process phase
   // ********************
   assign sum = {1'b0, acc_r} + {1'b0, opnd_r};
   assign lo_sum = {1'b0, acc_r[3:0]} + {1'b0, opnd_r[3:0]};

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         res_r <= 8'h00;
         flg_r <= `ILO_STAT_RST;
      end
      else if (busy_r && phase_r == ILO_PH_PROC)
      begin
         flg_r <= stat_r;
         case (dbus.op)
            ILO_OP_ADD:
            begin
               res_r <= sum[7:0];
               flg_r[`ILO_FLG_C] <= sum[8];
               flg_r[`ILO_FLG_DIGIT] <= lo_sum[4];
               flg_r[`ILO_FLG_Z] <= (sum[7:0] == 8'h00);
               flg_r[`ILO_FLG_N] <= sum[7];
               flg_r[`ILO_FLG_OVFL] <= (acc_r[7] == opnd_r[7]) && (sum[7] != acc_r[7]);
            end
            ILO_OP_BSET:
            begin
               res_r <= opnd_r | (8'h01 << dbus.bit_sel);
            end
            ILO_OP_FILL:
            begin
               res_r <= `ILO_FILL_VAL;
            end
            default:
            begin
               res_r <= opnd_r; // Unrecognised word: no effect
            end
         endcase
      end
   end

   // ********************
   // Write phase
   // ********************
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         we_r <= 1'b0;
         wa_r <= '0;
         wd_r <= 8'h00;
         acc_r <= `ILO_ACC_RST;
         stat_r <= `ILO_STAT_RST;
         done_r <= 1'b0;
      end
      else
      begin
         we_r <= 1'b0;
         done_r <= 1'b0;
         if (busy_r && phase_r == ILO_PH_WRITE)
         begin
            done_r <= 1'b1;
            wa_r <= ea_r;
            wd_r <= res_r;
            case (dbus.op)
               ILO_OP_ADD:
               begin
                  stat_r <= flg_r;
                  if (dbus.dest_mem)
                  begin
                     we_r <= 1'b1;
                  end
                  else
                  begin
                     acc_r <= res_r;
                  end
               end
               ILO_OP_BSET, ILO_OP_FILL:
               begin
                  we_r <= 1'b1; // Flags left alone
               end
               default:
               begin
                  we_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // Read address register: points at operand from the read phase on
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         mem_addr <= '0;
      end
      else if (busy_r && phase_r == ILO_PH_DECODE)
      begin
         mem_addr <= ea;
      end
   end

   // ********************
   // Outputs
   // ********************
   assign mem_we = we_r;
   assign mem_waddr = wa_r;
   assign mem_wdata = wd_r;
   assign acc = acc_r;
   assign status = stat_r;
   assign phase = phase_r;
   assign busy = busy_r;
   assign done = done_r;
   assign indexed_used = idx_r;
endmodule

//--- ilo_exec_monitor.sv
// Checker of port timing and results for the indexed execution unit
`timescale 1ns/1ns
module ilo_exec_monitor
import ilo_pkg::*;
#(
   parameter int AW = 12
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Inputs of the unit
   input wire logic extended_set_cfg_bit,
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   input wire logic [AW-1:0] frame_pointer_reg,
   // Outputs of the unit
   input wire logic mem_we,
   input wire logic [AW-1:0] mem_waddr,
   input wire logic [7:0] mem_wdata,
   input wire logic [4:0] status,
   input wire ilo_pkg::ilo_phase_t phase,
   input wire logic busy,
   input wire logic done
);
   // ***
   // Word in flight
   // ***
   logic take; // Word accepted at this edge
   logic [AW+16:0] in_r; // Mode, pointer, word at issue
   logic [AW+16:0] out_r; // Same, one edge late, so a back-to-back issue cannot hide it
   logic [15:0] wi;
   logic [AW-1:0] wf;
   logic wlo; // Operand taken as an offset
   assign take = instr_valid && (!busy || phase == ILO_PH_WRITE);
   assign wi = out_r[15:0];
   assign wf = out_r[AW+15:16];
   assign wlo = out_r[AW+16] && !wi[8] && wi[7:0] <= 8'h5f;
   // Capture at issue, then delay to the write cycle
   always_ff @(posedge clock)
   begin
      if (take)
         in_r <= {extended_set_cfg_bit, frame_pointer_reg, instr};
      out_r <= in_r;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // ***
   // Assertions
   // ***
   done_after_take_a:
      assert property (take |-> ##5 done) else $error("Done late or missing");
   phase_walk_a:
      assert property (take |=> phase == ILO_PH_DECODE ##1 phase == ILO_PH_READ
         ##1 phase == ILO_PH_PROC ##1 phase == ILO_PH_WRITE) else $error("Bad phase order");
   done_pulse_a:
      assert property (done |=> !done) else $error("Done longer than one cycle");
   we_with_done_a:
      assert property (mem_we |-> done) else $error("Write without done");
   add_dest_a:
      assert property (done && wi[15:10] == 6'h09 |-> mem_we == wi[9])
      else $error("Add destination wrong");
   flags_kept_a:
      assert property (done && wi[15:10] != 6'h09 |-> $stable(status))
      else $error("Flags changed");
   fill_ones_a:
      assert property (mem_we && wi[15:8] == 8'h68 |-> mem_wdata == 8'hff)
      else $error("Fill value wrong");
   bit_set_a:
      assert property (mem_we && wi[15:12] == 4'h8 |-> mem_wdata[wi[11:9]])
      else $error("Bit not set");
   idx_addr_a:
      assert property (mem_we && wlo |-> mem_waddr == wf + AW'(wi[7:0]))
      else $error("Indexed address wrong");
   plain_addr_a:
      assert property (mem_we && !out_r[AW+16] && !wi[8]
         |-> mem_waddr == AW'({{4{wi[7]}}, wi[7:0]})) else $error("Plain address wrong");
   // Main scenarios
   cover property (take ##4 take);
   cover property (mem_we && wlo);
   cover property (done && !mem_we && wi[15:10] == 6'h09);
endmodule
bind ilo_exec ilo_exec_monitor #(.AW(AW)) ilo_exec_monitor_i (.clock(clock), .rst(rst),
   .extended_set_cfg_bit(extended_set_cfg_bit), .instr_valid(instr_valid), .instr(instr),
   .frame_pointer_reg(frame_pointer_reg), .mem_we(mem_we), .mem_waddr(mem_waddr),
   .mem_wdata(mem_wdata), .status(status), .phase(phase), .busy(busy), .done(done));

//--- ilo_pkg.sv
// Types shared by the indexed literal offset execution block
package ilo_pkg;
   // Four phases of one instruction cycle
   typedef enum logic [1:0]
   {
      ILO_PH_DECODE = 2'b00,
      ILO_PH_READ = 2'b01,
      ILO_PH_PROC = 2'b10,
      ILO_PH_WRITE = 2'b11
   } ilo_phase_t;
   // Decoded operation
   typedef enum logic [1:0]
   {
      ILO_OP_NONE = 2'b00,
      ILO_OP_ADD = 2'b01,
      ILO_OP_BSET = 2'b10,
      ILO_OP_FILL = 2'b11
   } ilo_op_t;
endpackage

//--- test_indexed_literal_offset_exec.sv
// Self-checking bench for the indexed execution unit
`timescale 1ns/1ns
`include "ilo_consts.svh"
module test_indexed_literal_offset_exec;
import ilo_pkg::*;
   // ***
   // Signals and reference state
   // ***
   typedef struct packed {logic we; logic [11:0] a; logic [7:0] d;
      logic [7:0] acc; logic [4:0] st; logic ix; logic k;} ilo_exp_t;
   logic clock = 0, rst = 1, xcfg = 0, iv = 0;
   logic [15:0] ins = 0;
   logic [11:0] fp = 0, maddr, waddr;
   logic [3:0] bs = 0;
   logic [7:0] rdata, wdata, acc, ra = 0;
   logic [4:0] st, rs = 0;
   logic we, busy, done, idx;
   ilo_phase_t ph;
   logic [7:0] mem [4096]; // Data memory seen by the unit
   logic [7:0] rm [4096]; // Expected memory
   ilo_exp_t q[$], de; // Pending results
   int n_mismatch = 0, check_count = 0, n;
   ilo_exec #(.AW(12)) ilo_exec_i (.clock(clock), .rst(rst), .extended_set_cfg_bit(xcfg),
      .instr_valid(iv), .instr(ins), .frame_pointer_reg(fp), .bank_sel(bs),
      .mem_addr(maddr), .mem_rdata(rdata), .mem_we(we), .mem_waddr(waddr),
      .mem_wdata(wdata), .acc(acc), .status(st), .phase(ph), .busy(busy), .done(done),
      .indexed_used(idx));
   initial forever #50 clock = ~clock;
   assign rdata = mem[maddr];
   // Memory takes the write at the edge that ends the pulse
   always @(posedge clock)
      if (we === 1'b1)
         mem[waddr] <= wdata;
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Effective address: offsets only in extended mode with access bit 0
   function automatic logic [11:0] eff(logic x, logic a, logic [7:0] f);
      if (!a && x && f <= 8'h5f)
         return fp + 12'(f);
      if (a)
         return {bs, f};
      return {{4{f[7]}}, f};
   endfunction
   // Random word, fields biased to the offset boundary
   function automatic logic [15:0] word;
      logic [7:0] f;
      f = ($urandom % 2) ? 8'($urandom) : (($urandom % 2) ? 8'h5f : 8'h60);
      case ($urandom % 5)
         0, 1: return {`ILO_OP_ADD_HI, 1'($urandom), 1'($urandom), f};
         2: return {`ILO_OP_BITSET_HI, 3'($urandom), 1'($urandom), f};
         3: return {`ILO_OP_FILL_HI, f};
         default: return 16'hffff;
      endcase
   endfunction
   // Predict one word, issue it, return at its write phase
   task automatic issue(logic [15:0] w);
      ilo_exp_t e;
      logic [8:0] s;
      logic [7:0] m;
      int c;
      e = '{0, eff(xcfg, w[8], w[7:0]), 8'hff, ra, rs, xcfg && !w[8] && w[7:0] <= 8'h5f, 1};
      m = rm[e.a];
      s = ra + m;
      if (w[15:8] == `ILO_OP_FILL_HI)
         e.we = 1;
      else if (w[15:10] == `ILO_OP_ADD_HI)
      begin
         e.d = s[7:0];
         e.st = {s[7], ra[7] == m[7] && s[7] != ra[7], s[7:0] == 0,
            5'(ra[3:0]) + 5'(m[3:0]) > 5'h0f, s[8]};
         e.we = w[9];
         if (!w[9])
            e.acc = s[7:0];
      end
      else if (w[15:12] == `ILO_OP_BITSET_HI)
      begin
         e.we = 1;
         e.d = m | (8'h01 << w[11:9]);
      end
      else
         e.k = 0;
      if (e.we)
         rm[e.a] = e.d;
      ra = e.acc;
      rs = e.st;
      q.push_back(e);
      iv <= 1;
      ins <= w;
      @(posedge clock);
      iv <= 0;
      #1;
      for (c = 0; ph !== ILO_PH_WRITE && c < 8; c++)
      begin
         @(posedge clock);
         #1;
      end
      if (c == 8)
      begin
         check(0, 1);
         end_sim();
      end
   endtask
   // Result check in the done cycle
   always @(posedge clock)
   begin
      #1;
      if (done === 1'b1)
      begin
         if (q.size() == 0)
            check(0, 1);
         else
         begin
            de = q.pop_front();
            check(we, de.we);
            if (de.we)
            begin
               check(waddr, de.a);
               check(wdata, de.d);
            end
            check(acc, de.acc);
            check(st, de.st);
            if (de.k)
               check(idx, de.ix);
         end
      end
   end
   task automatic idle;
      for (n = 0; busy !== 1'b0 && n < 10; n++)
      begin
         @(posedge clock);
         #1;
      end
      if (n == 10)
      begin
         check(0, 1);
         end_sim();
      end
   endtask
   initial
   begin
      void'($urandom(32'h1926));
      for (int i = 0; i < 4096; i++)
      begin
         mem[i] = 8'($urandom);
         rm[i] = mem[i];
      end
      repeat (2) @(posedge clock);
      rst <= 0;
      #1;
      check({acc, st, busy, done, we, ph}, 0);
      // Corners: pointer wrap, top offset, first plain address
      xcfg <= 1;
      fp <= 12'hff0;
      #1;
      issue({`ILO_OP_ADD_HI, 2'b10, 8'h5f});
      issue({`ILO_OP_BITSET_HI, 4'he, 8'h00});
      issue({`ILO_OP_FILL_HI, 8'h60});
      for (int i = 0; i < 60; i++)
      begin
         idle();
         xcfg <= 1'($urandom);
         fp <= 12'($urandom);
         bs <= 4'($urandom);
         @(posedge clock);
         #1;
         repeat (1 + $urandom % 3) issue(word());
      end
      idle();
      @(posedge clock);
      #1;
      check(q.size(), 0);
      end_sim();
   end
   initial
   begin
      #3000000;
      n_mismatch++;
      end_sim();
   end
endmodule
